// ===== core/rss_sub_unit.sv
// package of shared types and a subtractor with its flag logic
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// shared types and constants
// ----------------------------------------------------------------
package rss_pkg;

  localparam int DATA_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam int MSB_POS = 7;
  localparam int NIB_MSB_POS = 3;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam int SKIP_CLASS_CYCLES = 2;

  typedef enum logic [4:0] {
    OP_IDLE_NOP = 5'h00,
    OP_ROTATE_LEFT_VIA_CARRY = 5'h01,
    OP_ROTATE_LEFT_VIA_CARRY_TO_ACCUMULATOR = 5'h02,
    OP_ROTATE_RIGHT_MEMORY = 5'h03,
    OP_ROTATE_RIGHT_TO_ACCUMULATOR = 5'h04,
    OP_ROTATE_RIGHT_VIA_CARRY = 5'h05,
    OP_ROTATE_RIGHT_VIA_CARRY_TO_ACCUMULATOR = 5'h06,
    OP_MINUS_INTO_ACCUMULATOR = 5'h07,
    OP_MINUS_INTO_MEMORY = 5'h08,
    OP_BORROW_MINUS_INTO_ACCUMULATOR = 5'h09,
    OP_BORROW_MINUS_INTO_MEMORY = 5'h0A,
    OP_DECREMENT_SKIP_IF_NIL = 5'h0B,
    OP_DECREMENT_SKIP_IF_NIL_TO_ACCUMULATOR = 5'h0C,
    OP_INCREMENT_SKIP_IF_NIL = 5'h0D,
    OP_INCREMENT_SKIP_IF_NIL_TO_ACCUMULATOR = 5'h0E,
    OP_BIT_HIGH_SKIP = 5'h0F,
    OP_SET_BYTE = 5'h10,
    OP_SET_BIT = 5'h11
  } rss_op_t;

  typedef struct packed {
    logic signedWrapFlag;
    logic zero;
    logic halfCarryFlag;
    logic carry;
  } rss_flags_t;

  localparam rss_flags_t FLAGS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    rss_op_t op;
    logic [2:0] bitSel;
    logic [7:0] operand;
  } rss_req_t;

  typedef enum logic [0:0] {
    ST_ISSUE = 1'b0,
    ST_DUMMY = 1'b1
  } rss_state_t;

endpackage : rss_pkg

// ----------------------------------------------------------------
// subtractor: a - b - borrowIn with carry as inverted borrow
// ----------------------------------------------------------------
module rss_sub_unit
  import rss_pkg::*;
(
  // operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic borrowIn,
  // results
  output logic [7:0] difference,
  output rss_flags_t flags
);

  logic [8:0] fullDiff;
  logic [4:0] nibDiff;

  assign fullDiff = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
  assign nibDiff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]}
    - {4'h0, borrowIn};
  assign difference = fullDiff[7:0];
  // negative result shows as a borrow out of the top bit
  assign flags.carry = ~fullDiff[DATA_W];
  assign flags.halfCarryFlag = ~nibDiff[NIB_MSB_POS + 1];
  assign flags.signedWrapFlag = (minuend[MSB_POS] ^ subtrahend[MSB_POS])
    & (minuend[MSB_POS] ^ fullDiff[MSB_POS]);
  assign flags.zero = (fullDiff[7:0] == 8'h00);

endmodule : rss_sub_unit

`default_nettype wire

// ===== core/rss_datapath.sv
// rotate, subtract, set and skip execution datapath
`timescale 1ns/1ps
`default_nettype none

// How it works
// - rotate left via carry: carry into bit 0, bit 7 into carry
// - accumulator form puts rotated byte in accumulator only
// - rotate-right: bit 0 into bit 7, memory or accumulator, no flags
// - rotate-right-via-carry: carry into bit 7, old bit 0 into carry
// - borrow-minus: accumulator minus operand minus inverted carry
// - memory forms of subtract write difference to memory byte
// - subtract carry is zero on negative result, one otherwise
// - subtracts update wrap, zero, half-carry and carry flags only
// - plain subtract ignores incoming carry, result to accumulator or memory
// - decrement-skip writes byte minus one back, skips when zero
// - accumulator decrement-skip loads byte minus one, skips when zero
// - increment-skip writes byte plus one back, skips on wrap to zero
// - accumulator increment-skip loads byte plus one, skips when zero
// - bit-high-skip skips when the selected bit is one
// - every skip-class operation takes two cycles with a dummy slot
// - set-byte writes all ones to memory, no flags
// - set-bit forces only the selected bit to one, no flags

module rss_datapath
  import rss_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // operation request
  input wire logic reqValid,
  input wire rss_req_t req,
  output logic reqReady,
  // accumulator and carry preload from the rest of the core
  input wire logic accLoad,
  input wire logic [7:0] accLoadData,
  input wire logic carryLoad,
  input wire logic carryLoadData,
  // memory write-back
  output logic memWe,
  output logic [7:0] memWdata,
  // architectural state
  output logic [7:0] acc,
  output rss_flags_t flags,
  // completion and skip
  output logic done,
  output logic skipNext
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bitMask(input logic [2:0] idx);
    bitMask = BYTE_ONE << idx;
  endfunction : bitMask

  function automatic logic isZero(input logic [7:0] v);
    isZero = (v == 8'h00);
  endfunction : isZero

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rss_state_t state_r;
  rss_state_t state_nxt;
  logic [7:0] acc_r;
  rss_flags_t flags_r;
  logic memWe_r;
  logic [7:0] memWdata_r;
  logic done_r;
  logic skip_r;

  // ----------------------------------------------------------------
  // operand paths
  // ----------------------------------------------------------------
  wire logic taken = reqValid & reqReady;
  wire logic [7:0] opnd = req.operand;
  wire logic carryIn = flags_r.carry;
  wire logic [7:0] selMask = bitMask(req.bitSel);

  wire logic [7:0] rotLeftC = {opnd[6:0], carryIn};
  wire logic [7:0] rotRight = {opnd[0], opnd[MSB_POS:1]};
  wire logic [7:0] rotRightC = {carryIn, opnd[MSB_POS:1]};
  wire logic [7:0] decVal = opnd - BYTE_ONE;
  wire logic [7:0] incVal = opnd + BYTE_ONE;
  wire logic [7:0] setBitVal = opnd | selMask;
  wire logic bitHigh = (opnd & selMask) != 8'h00;

  wire logic isBorrowOp = (req.op == OP_BORROW_MINUS_INTO_ACCUMULATOR)
    | (req.op == OP_BORROW_MINUS_INTO_MEMORY);
  // plain subtract feeds no borrow, borrow form feeds inverted carry
  wire logic subBorrow = isBorrowOp & ~carryIn;

  logic [7:0] subDiff;
  rss_flags_t subFlags;

  rss_sub_unit u_sub (
    .minuend(acc_r),
    .subtrahend(opnd),
    .borrowIn(subBorrow),
    .difference(subDiff),
    .flags(subFlags)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [7:0] result;
  logic toMem;
  logic toAcc;
  logic carryUpd;
  logic carryVal;
  logic subUpd;
  logic skipClass;
  logic skipCond;

  always_comb begin
    result = opnd;
    toMem = 1'b0;
    toAcc = 1'b0;
    carryUpd = 1'b0;
    carryVal = carryIn;
    subUpd = 1'b0;
    skipClass = 1'b0;
    skipCond = 1'b0;
    case (req.op)
      OP_ROTATE_LEFT_VIA_CARRY: begin
        result = rotLeftC;
        toMem = 1'b1;
        carryUpd = 1'b1;
        carryVal = opnd[MSB_POS];
      end
      OP_ROTATE_LEFT_VIA_CARRY_TO_ACCUMULATOR: begin
        result = rotLeftC;
        toAcc = 1'b1;
        carryUpd = 1'b1;
        carryVal = opnd[MSB_POS];
      end
      OP_ROTATE_RIGHT_MEMORY: begin
        result = rotRight;
        toMem = 1'b1;
      end
      OP_ROTATE_RIGHT_TO_ACCUMULATOR: begin
        result = rotRight;
        toAcc = 1'b1;
      end
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        result = rotRightC;
        toMem = 1'b1;
        carryUpd = 1'b1;
        carryVal = opnd[0];
      end
      OP_ROTATE_RIGHT_VIA_CARRY_TO_ACCUMULATOR: begin
        result = rotRightC;
        toAcc = 1'b1;
        carryUpd = 1'b1;
        carryVal = opnd[0];
      end
      OP_MINUS_INTO_ACCUMULATOR, OP_BORROW_MINUS_INTO_ACCUMULATOR: begin
        result = subDiff;
        toAcc = 1'b1;
        subUpd = 1'b1;
      end
      OP_MINUS_INTO_MEMORY, OP_BORROW_MINUS_INTO_MEMORY: begin
        result = subDiff;
        toMem = 1'b1;
        subUpd = 1'b1;
      end
      OP_DECREMENT_SKIP_IF_NIL: begin
        result = decVal;
        toMem = 1'b1;
        skipClass = 1'b1;
        skipCond = isZero(decVal);
      end
      OP_DECREMENT_SKIP_IF_NIL_TO_ACCUMULATOR: begin
        result = decVal;
        toAcc = 1'b1;
        skipClass = 1'b1;
        skipCond = isZero(decVal);
      end
      OP_INCREMENT_SKIP_IF_NIL: begin
        result = incVal;
        toMem = 1'b1;
        skipClass = 1'b1;
        skipCond = isZero(incVal);
      end
      OP_INCREMENT_SKIP_IF_NIL_TO_ACCUMULATOR: begin
        result = incVal;
        toAcc = 1'b1;
        skipClass = 1'b1;
        skipCond = isZero(incVal);
      end
      OP_BIT_HIGH_SKIP: begin
        skipClass = 1'b1;
        skipCond = bitHigh;
      end
      OP_SET_BYTE: begin
        result = BYTE_ALL_ONES;
        toMem = 1'b1;
      end
      OP_SET_BIT: begin
        result = setBitVal;
        toMem = 1'b1;
      end
      default: begin
        result = opnd;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // a skip-class op holds the issue slot busy for one dummy cycle
  assign reqReady = (state_r == ST_ISSUE);
  assign state_nxt = (taken & skipClass) ? ST_DUMMY : ST_ISSUE;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_ISSUE;
      done_r <= 1'b0;
      memWe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_r <= (taken & ~skipClass) | (state_r == ST_DUMMY);
      memWe_r <= taken & toMem;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      memWdata_r <= ACC_RESET;
      skip_r <= 1'b0;
    end else if (taken) begin
      memWdata_r <= result;
      skip_r <= skipClass & skipCond;
    end
  end

  // a preload loses to an operation taken in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_r <= ACC_RESET;
    end else if (taken & toAcc) begin
      acc_r <= result;
    end else if (accLoad & ~taken) begin
      acc_r <= accLoadData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flags_r <= FLAGS_RESET;
    end else if (taken & subUpd) begin
      flags_r <= subFlags;
    end else if (taken & carryUpd) begin
      flags_r.carry <= carryVal;
    end else if (carryLoad & ~taken) begin
      flags_r.carry <= carryLoadData;
    end
  end

  assign memWe = memWe_r;
  assign memWdata = memWdata_r;
  assign acc = acc_r;
  assign flags = flags_r;
  assign done = done_r;
  assign skipNext = skip_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_takeOp(rss_op_t o);
    taken && req.op == o;
  endsequence

  sequence s_dummyThenIdle;
    !reqReady ##1 reqReady;
  endsequence

  property p_rotl_mem;
    @(posedge clock) disable iff (rst)
    s_takeOp(OP_ROTATE_LEFT_VIA_CARRY) |=> memWe
      && memWdata == {$past(opnd[6:0]), $past(carryIn)}
      && flags.carry == $past(opnd[MSB_POS]);
  endproperty
  a_rotl_mem: assert property (p_rotl_mem)
    else $error("rotate left via carry wrong");

  property p_rotl_acc;
    @(posedge clock) disable iff (rst)
    s_takeOp(OP_ROTATE_LEFT_VIA_CARRY_TO_ACCUMULATOR) |=> !memWe
      && acc == {$past(opnd[6:0]), $past(carryIn)};
  endproperty
  a_rotl_acc: assert property (p_rotl_acc)
    else $error("rotate left to accumulator wrong");

  property p_rotr_flags;
    @(posedge clock) disable iff (rst)
    s_takeOp(OP_ROTATE_RIGHT_TO_ACCUMULATOR) |=> $stable(flags)
      && acc == {$past(opnd[0]), $past(opnd[MSB_POS:1])};
  endproperty
  a_rotr_flags: assert property (p_rotr_flags)
    else $error("rotate right changed flags or value");

  property p_rotr_carry;
    @(posedge clock) disable iff (rst)
    s_takeOp(OP_ROTATE_RIGHT_VIA_CARRY) |=> memWe
      && memWdata[MSB_POS] == $past(carryIn)
      && flags.carry == $past(opnd[0]);
  endproperty
  a_rotr_carry: assert property (p_rotr_carry)
    else $error("rotate right via carry wrong");

  property p_borrow_acc;
    @(posedge clock) disable iff (rst)
    s_takeOp(OP_BORROW_MINUS_INTO_ACCUMULATOR) |=> acc ==
      8'($past(acc_r) - $past(opnd) - {7'h00, ~$past(carryIn)});
  endproperty
  a_borrow_acc: assert property (p_borrow_acc)
    else $error("borrow subtract value wrong");

  property p_minus_mem;
    @(posedge clock) disable iff (rst)
    s_takeOp(OP_MINUS_INTO_MEMORY) |=> memWe && $stable(acc)
      && memWdata == 8'($past(acc_r) - $past(opnd))
      && flags.carry == ($past(acc_r) >= $past(opnd));
  endproperty
  a_minus_mem: assert property (p_minus_mem)
    else $error("memory subtract or carry wrong");

  property p_dsz;
    @(posedge clock) disable iff (rst)
    s_takeOp(OP_DECREMENT_SKIP_IF_NIL) |=> memWe && $stable(flags)
      && skipNext == ($past(opnd) == BYTE_ONE);
  endproperty
  a_dsz: assert property (p_dsz)
    else $error("decrement skip wrong");

  property p_isza;
    @(posedge clock) disable iff (rst)
    s_takeOp(OP_INCREMENT_SKIP_IF_NIL_TO_ACCUMULATOR) |=> !memWe
      && acc == 8'($past(opnd) + 8'h01)
      && skipNext == ($past(opnd) == BYTE_ALL_ONES);
  endproperty
  a_isza: assert property (p_isza)
    else $error("increment skip to accumulator wrong");

  property p_two_cycles;
    @(posedge clock) disable iff (rst)
    (taken && skipClass) |=> s_dummyThenIdle ##0 done;
  endproperty
  a_two_cycles: assert property (p_two_cycles)
    else $error("skip op did not take two cycles");

  property p_setbit;
    @(posedge clock) disable iff (rst)
    s_takeOp(OP_SET_BIT) |=> memWe && $stable(flags)
      && memWdata == ($past(opnd) | bitMask($past(req.bitSel)));
  endproperty
  a_setbit: assert property (p_setbit)
    else $error("set bit wrong");

endmodule : rss_datapath

`default_nettype wire

// ===== test/rss_datapath_bench.sv
// self-checking bench for the rotate, subtract, set and skip datapath
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin failCount++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end

module rss_datapath_bench
  import rss_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock;
  logic rst;
  logic reqValid;
  rss_req_t req;
  logic reqReady;
  logic accLoad;
  logic [7:0] accLoadData;
  logic carryLoad;
  logic carryLoadData;
  logic memWe;
  logic [7:0] memWdata;
  logic [7:0] acc;
  rss_flags_t flags;
  logic done;
  logic skipNext;
  int failCount = 0;
  int nChecks = 0;
  logic [31:0] seed = 32'h7ED5;
  logic [7:0] eAcc;
  rss_flags_t eFl;

  rss_datapath dut (
    .clock(clock), .rst(rst), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .accLoad(accLoad), .accLoadData(accLoadData),
    .carryLoad(carryLoad), .carryLoadData(carryLoadData),
    .memWe(memWe), .memWdata(memWdata), .acc(acc), .flags(flags),
    .done(done), .skipNext(skipNext)
  );

  initial clock = 1'b0;
  always #20 clock = ~clock;

  // ----------------------------------------------------------------
  // expectation model
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // updates eAcc/eFl; op codes used numerically to keep lines short
  function automatic void model(input logic [4:0] o, input logic [7:0] m,
      input logic [2:0] b, output logic we, output logic [7:0] r,
      output logic sk, output logic isk);
    logic [8:0] d;
    logic [4:0] n;
    logic bin;
    sk = 1'b0;
    r = 8'h00;
    bin = (o == 5'h09 || o == 5'h0A) ? ~eFl.carry : 1'b0;
    isk = o inside {5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F};
    case (o)
      5'h01, 5'h02: begin
        r = {m[6:0], eFl.carry};
        eFl.carry = m[7];
      end
      5'h03, 5'h04: r = {m[0], m[7:1]};
      5'h05, 5'h06: begin
        r = {eFl.carry, m[7:1]};
        eFl.carry = m[0];
      end
      5'h07, 5'h08, 5'h09, 5'h0A: begin
        d = {1'b0, eAcc} - {1'b0, m} - {8'h00, bin};
        n = {1'b0, eAcc[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
        r = d[7:0];
        eFl.carry = ~d[8];
        eFl.halfCarryFlag = ~n[4];
        eFl.zero = (r == 8'h00);
        eFl.signedWrapFlag = (eAcc[7] ^ m[7]) & (r[7] ^ eAcc[7]);
      end
      5'h0B, 5'h0C: begin
        r = m - 8'h01;
        sk = (r == 8'h00);
      end
      5'h0D, 5'h0E: begin
        r = m + 8'h01;
        sk = (r == 8'h00);
      end
      5'h0F: sk = m[b];
      5'h10: r = 8'hFF;
      5'h11: r = m | (8'h01 << b);
      default: r = 8'h00;
    endcase
    we = o inside {5'h01, 5'h03, 5'h05, 5'h08, 5'h0A, 5'h0B, 5'h0D,
        5'h10, 5'h11};
    if (o inside {5'h02, 5'h04, 5'h06, 5'h07, 5'h09, 5'h0C, 5'h0E}) begin
      eAcc = r;
    end
  endfunction : model

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  // reqValid is left high; a held request in the dummy slot must be refused
  task automatic do_op(input logic [4:0] o, input logic [7:0] m,
      input logic [2:0] b);
    logic we;
    logic sk;
    logic isk;
    logic [7:0] wd;
    model(o, m, b, we, wd, sk, isk);
    reqValid = 1'b1;
    req = '{rss_op_t'(o), b, m};
    @(posedge clock);
    #1;
    `CHK(memWe, we)
    if (we) `CHK(memWdata, wd)
    `CHK(acc, eAcc)
    `CHK(flags, eFl)
    `CHK(skipNext, sk)
    `CHK(reqReady, ~isk)
    `CHK(done, ~isk)
    if (isk) begin
      @(posedge clock);
      #1;
      `CHK(done, 1'b1)
      `CHK(memWe, 1'b0)
      `CHK(reqReady, 1'b1)
    end
  endtask : do_op

  task automatic preload(input logic [7:0] a, input logic c);
    reqValid = 1'b0;
    accLoad = 1'b1;
    accLoadData = a;
    carryLoad = 1'b1;
    carryLoadData = c;
    @(posedge clock);
    #1;
    accLoad = 1'b0;
    carryLoad = 1'b0;
    eAcc = a;
    eFl.carry = c;
  endtask : preload

  task automatic results();
    if (failCount == 0 && nChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    req = '0;
    accLoad = 1'b0;
    accLoadData = 8'h00;
    carryLoad = 1'b0;
    carryLoadData = 1'b0;
    eAcc = 8'h00;
    eFl = FLAGS_RESET;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    `CHK(acc, 8'h00)
    `CHK(flags, FLAGS_RESET)
    `CHK({reqReady, done, memWe, skipNext}, 4'h8)
    preload(8'h00, 1'b0);
    do_op(5'h01, 8'h81, 3'h0);
    do_op(5'h02, 8'h81, 3'h0);
    do_op(5'h05, 8'h01, 3'h0);
    do_op(5'h06, 8'h80, 3'h0);
    do_op(5'h03, 8'h01, 3'h0);
    do_op(5'h04, 8'h01, 3'h0);
    preload(8'h10, 1'b0);
    do_op(5'h09, 8'h01, 3'h0);
    preload(8'h80, 1'b0);
    do_op(5'h07, 8'h01, 3'h0);
    preload(8'h00, 1'b0);
    do_op(5'h07, 8'h00, 3'h0);
    do_op(5'h07, 8'h01, 3'h0);
    do_op(5'h0A, 8'h7F, 3'h0);
    // a preload coinciding with a taken request must lose
    accLoad = 1'b1;
    accLoadData = ~eAcc;
    carryLoad = 1'b1;
    carryLoadData = 1'b1;
    do_op(5'h08, 8'h10, 3'h0);
    accLoad = 1'b0;
    carryLoad = 1'b0;
    do_op(5'h0B, 8'h01, 3'h0);
    do_op(5'h0B, 8'h00, 3'h0);
    do_op(5'h0C, 8'h01, 3'h0);
    do_op(5'h0D, 8'hFF, 3'h0);
    do_op(5'h0E, 8'hFF, 3'h0);
    do_op(5'h0E, 8'h00, 3'h0);
    for (int i = 0; i < 8; i++) begin
      do_op(5'h0F, 8'h01 << i, 3'(i));
      do_op(5'h0F, ~(8'h01 << i), 3'(i));
      do_op(5'h11, 8'h00, 3'(i));
    end
    do_op(5'h10, 8'h00, 3'h0);
    do_op(5'h00, 8'h55, 3'h0);
    for (int i = 0; i < 18; i++) begin
      do_op(5'(i), 8'(rnd()), 3'(rnd()));
    end
    for (int i = 0; i < 400; i++) begin
      if (rnd() % 8 == 0) begin
        preload(8'(seed >> 8), seed[20]);
      end
      do_op(5'(rnd() % 18), 8'(seed >> 8), 3'(seed >> 16));
    end
    reqValid = 1'b0;
    @(posedge clock);
    #1;
    // completion and write strobes are single-cycle pulses
    `CHK({done, memWe}, 2'b00)
    results();
  end

  // about 660 cycles expected; the limit leaves a wide margin
  initial begin
    repeat (5000) @(posedge clock);
    failCount++;
    results();
  end

endmodule : rss_datapath_bench

`default_nettype wire
